/* File: common/ofw_pkg.sv */
// Constants shared by the output word formatting block
package ofw_pkg;

    localparam int ADDR_W       = 4;
    localparam int WORD_W       = 16;
    localparam int SMP_W        = 20;
    localparam int RES_W        = 32;
    localparam int GW_W         = 6;
    localparam int GYRO_BASE_W  = 16;
    localparam int ACCEL_BASE_W = 20;
    localparam int DEC_W        = 4;
    localparam int BART_W       = 2;
    localparam int HIST         = 8;
    localparam int FIFO_DEPTH   = 16;
    localparam int AXES         = 6;

    localparam logic [ADDR_W-1:0] REG_DEC     = 4'h0;
    localparam logic [ADDR_W-1:0] REG_BART    = 4'h1;
    localparam logic [ADDR_W-1:0] REG_GX_UP   = 4'h2;
    localparam logic [ADDR_W-1:0] REG_AZ_LOW  = 4'hD;
    localparam logic [ADDR_W-1:0] REG_BURST   = 4'hE;
    localparam logic [ADDR_W-1:0] REG_STATUS  = 4'hF;

    localparam logic [DEC_W-1:0]  DEC_RST     = 4'h0;
    localparam logic [BART_W-1:0] BART_RST    = 2'h0;
    localparam logic [2:0]        BURST_WORDS = 3'h6;

endpackage : ofw_pkg

/* File: verilog/ofw_fifo.sv */
// Word FIFO with valid/ready on both sides
`timescale 1ns/1ps
module ofw_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 16
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [W-1:0]               in_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [W-1:0]                    out_data,
    output logic [$clog2(DEPTH):0]          level
);
    localparam int PW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [PW:0]  wr_q;
    logic [PW:0]  rd_q;
    logic         push;
    logic         pop;

    assign level     = wr_q - rd_q;
    assign in_ready  = (level != (PW+1)'(DEPTH));
    assign out_valid = (wr_q != rd_q);
    assign out_data  = mem[rd_q[PW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_q[PW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            wr_q <= wr_q + (PW+1)'(push);
            rd_q <= rd_q + (PW+1)'(pop);
        end
    end

    a_fifo_bound: assert property (@(posedge clk) disable iff (rst)
        level <= (PW+1)'(DEPTH)) else $error("FIFO level beyond depth");

endmodule : ofw_fifo

/* File: verilog/ofw_acc.sv */
// Two-stage Bartlett moving sum followed by a decimating accumulator
`timescale 1ns/1ps
module ofw_acc #(
    parameter int IN_W   = 20,
    parameter int OUT_W  = 32,
    parameter int DEC_W  = 4,
    parameter int BART_W = 2,
    parameter int HIST   = 8
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    clr,
    input  wire logic                    in_valid,
    input  wire logic signed [IN_W-1:0]  in_data,
    input  wire logic [DEC_W-1:0]        dec_n,
    input  wire logic [BART_W-1:0]       bart_n,
    output logic                         out_valid,
    output logic [OUT_W-1:0]             out_data
);
    localparam int TW = $clog2(HIST);

    logic signed [OUT_W-1:0] x;
    logic signed [OUT_W-1:0] s1_q;
    logic signed [OUT_W-1:0] s2_q;
    logic signed [OUT_W-1:0] s1_d;
    logic signed [OUT_W-1:0] s2_d;
    logic signed [OUT_W-1:0] dec_q;
    logic signed [OUT_W-1:0] dec_sum;
    logic signed [OUT_W-1:0] h1_q [HIST];
    logic signed [OUT_W-1:0] h2_q [HIST];
    logic [DEC_W-1:0]        cnt_q;
    logic [TW-1:0]           tap;

    // Each stage sums 2^N samples; the oldest one drops out of the window
    always_comb
    begin
        x       = OUT_W'(in_data);
        tap     = TW'((1 << bart_n) - 1);
        s1_d    = s1_q + x - h1_q[tap];
        s2_d    = s2_q + s1_d - h2_q[tap];
        dec_sum = dec_q + s2_d;
    end

    always_ff @(posedge clk)
    begin
        if (rst || clr)
        begin
            for (int i = 0; i < HIST; i++)
            begin
                h1_q[i] <= '0;
                h2_q[i] <= '0;
            end
        end
        else if (in_valid)
        begin
            h1_q[0] <= x;
            h2_q[0] <= s1_d;
            for (int i = 1; i < HIST; i++)
            begin
                h1_q[i] <= h1_q[i-1];
                h2_q[i] <= h2_q[i-1];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst || clr)
        begin
            s1_q <= '0;
            s2_q <= '0;
        end
        else if (in_valid)
        begin
            s1_q <= s1_d;
            s2_q <= s2_d;
        end
    end

    // Setting N closes a result after N+1 summed samples
    always_ff @(posedge clk)
    begin
        if (rst || clr)
        begin
            dec_q     <= '0;
            cnt_q     <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end
        else
        begin
            out_valid <= 1'b0;
            if (in_valid)
            begin
                if (cnt_q == dec_n)
                begin
                    out_data  <= dec_sum;
                    out_valid <= 1'b1;
                    dec_q     <= '0;
                    cnt_q     <= '0;
                end
                else
                begin
                    dec_q <= dec_sum;
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end

    a_dec_close: assert property (@(posedge clk) disable iff (rst)
        (in_valid && !clr && cnt_q == dec_n) |=> out_valid)
        else $error("Decimation result missing after N+1 samples");

    a_dec_hold: assert property (@(posedge clk) disable iff (rst)
        (in_valid && cnt_q != dec_n) |=> !out_valid)
        else $error("Decimation result emitted early");

    a_bart_single: assert property (@(posedge clk) disable iff (rst)
        (in_valid && !clr && bart_n == '0 && $past(bart_n) == '0 && $past(!clr))
        |=> s1_q == $past(x))
        else $error("Single-tap window does not pass the sample");

endmodule : ofw_acc

/* File: verilog/ofw_top.sv */
// Output word formatting: filters, upper/lower split, register port and burst FIFO
//
// Function
// - Default settings give 16-bit gyro results, all in the gyro upper registers.
// - Extra gyro bits from accumulation go into the gyro lower registers.
// - Each doubling of summed samples in a stage adds one result bit.
// - Decimation setting N sums N+1 samples; seven gives three extra bits.
// - Bartlett setting N makes both stages sum 2^N; two gives four bits.
// - Default settings give 20-bit accelerometer results.
// - Accel upper holds top 16 bits; remaining bits sit in lower's top.
// - Extra accel bits from accumulation also go into the accel lower registers.
// - Burst reads return accelerometer values as 16-bit upper parts only.
`timescale 1ns/1ps
module ofw_top #(
    parameter int DEC_W      = ofw_pkg::DEC_W,
    parameter int BART_W     = ofw_pkg::BART_W,
    parameter int FIFO_DEPTH = ofw_pkg::FIFO_DEPTH
) (
    input  wire logic                        CLK_SYS,
    input  wire logic                        SYS_RST,
    input  wire logic [ofw_pkg::ADDR_W-1:0]  ADDR,
    input  wire logic [ofw_pkg::WORD_W-1:0]  WDATA,
    input  wire logic                        WR,
    input  wire logic                        RD,
    output logic      [ofw_pkg::WORD_W-1:0]  RDATA,
    input  wire logic                        SMP_VALID,
    output logic                             SMP_READY,
    input  wire logic [15:0]                 SMP_GYRO_X,
    input  wire logic [15:0]                 SMP_GYRO_Y,
    input  wire logic [15:0]                 SMP_GYRO_Z,
    input  wire logic [19:0]                 SMP_ACCEL_X,
    input  wire logic [19:0]                 SMP_ACCEL_Y,
    input  wire logic [19:0]                 SMP_ACCEL_Z,
    output logic                             RESULT_STROBE
);
    import ofw_pkg::*;

    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    // Bits of growth: ceil(log2(N+1)) from decimation plus N per Bartlett stage
    function automatic logic [GW_W-1:0] growth(input logic [DEC_W-1:0]  d,
                                                input logic [BART_W-1:0] b);
        logic [GW_W-1:0] g;
        g = '0;
        for (int k = 0; k < DEC_W; k++)
        begin
            if ((32'(d) + 32'd1) > (32'd1 << k))
            begin
                g = g + 1'b1;
            end
        end
        g = g + GW_W'(b) + GW_W'(b);
        return g;
    endfunction : growth

    // Left-justify a result of w bits: top word is upper, next word is lower
    function automatic logic [RES_W-1:0] left_just(input logic [RES_W-1:0] r,
                                                   input logic [GW_W-1:0]  w);
        logic [RES_W-1:0] s;
        s = r << (RES_W - 32'(w));
        return s;
    endfunction : left_just

    logic [DEC_W-1:0]   dec_q;
    logic [BART_W-1:0]  bart_q;
    logic               clr;
    logic               accept;
    logic [SMP_W-1:0]   smp_in   [AXES];
    logic [AXES-1:0]    acc_valid;
    logic [RES_W-1:0]   acc_data [AXES];
    logic               res_valid;
    logic [GW_W-1:0]    gyro_w;
    logic [GW_W-1:0]    accel_w;
    logic [WORD_W-1:0]  upper_q  [AXES];
    logic [WORD_W-1:0]  lower_q  [AXES];
    logic [2:0]         ser_cnt_q;
    logic [2:0]         ser_cnt_d;
    logic [2:0]         ser_idx;
    logic               push;
    logic               fifo_in_ready;
    logic               fifo_out_valid;
    logic               pop;
    logic [WORD_W-1:0]  fifo_out_data;
    logic [LW-1:0]      fifo_level;
    logic               smp_ready_q;
    logic [WORD_W-1:0]  rdata_q;
    logic               strobe_q;
    logic [3:0]         reg_idx;
    logic [15:0]        gx_low16;
    logic [2:0]         gx_low3;
    logic [15:0]        ax_hi16;
    logic [3:0]         ax_lo4;

    assign RDATA         = rdata_q;
    assign SMP_READY     = smp_ready_q;
    assign RESULT_STROBE = strobe_q;

    // Changing a filter setting restarts the windows so no mixed sums escape
    assign clr    = WR && (ADDR == REG_DEC || ADDR == REG_BART);
    assign accept = SMP_VALID && smp_ready_q;

    assign smp_in[0] = {{4{SMP_GYRO_X[15]}}, SMP_GYRO_X};
    assign smp_in[1] = {{4{SMP_GYRO_Y[15]}}, SMP_GYRO_Y};
    assign smp_in[2] = {{4{SMP_GYRO_Z[15]}}, SMP_GYRO_Z};
    assign smp_in[3] = SMP_ACCEL_X;
    assign smp_in[4] = SMP_ACCEL_Y;
    assign smp_in[5] = SMP_ACCEL_Z;

    for (genvar a = 0; a < AXES; a++)
    begin : g_axis
        ofw_acc #(
            .IN_W   (SMP_W),
            .OUT_W  (RES_W),
            .DEC_W  (DEC_W),
            .BART_W (BART_W),
            .HIST   (HIST)
        ) u_acc (
            .clk       (CLK_SYS),
            .rst       (SYS_RST),
            .clr       (clr),
            .in_valid  (accept),
            .in_data   (smp_in[a]),
            .dec_n     (dec_q),
            .bart_n    (bart_q),
            .out_valid (acc_valid[a]),
            .out_data  (acc_data[a])
        );
    end

    assign res_valid = acc_valid[0];
    assign gyro_w    = GW_W'(GYRO_BASE_W) + growth(dec_q, bart_q);
    assign accel_w   = GW_W'(ACCEL_BASE_W) + growth(dec_q, bart_q);

    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            dec_q  <= DEC_RST;
            bart_q <= BART_RST;
        end
        else if (WR)
        begin
            if (ADDR == REG_DEC)
            begin
                dec_q <= WDATA[DEC_W-1:0];
            end
            if (ADDR == REG_BART)
            begin
                bart_q <= WDATA[BART_W-1:0];
            end
        end
    end

    // Upper takes the top 16 result bits, lower the next bits, zero-filled
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            for (int i = 0; i < AXES; i++)
            begin
                upper_q[i] <= '0;
                lower_q[i] <= '0;
            end
        end
        else if (res_valid)
        begin
            for (int i = 0; i < 3; i++)
            begin
                {upper_q[i], lower_q[i]} <= left_just(acc_data[i], gyro_w);
            end
            for (int i = 3; i < AXES; i++)
            begin
                {upper_q[i], lower_q[i]} <= left_just(acc_data[i], accel_w);
            end
        end
    end

    // A finished result is queued as six upper words for the burst port
    assign ser_idx = BURST_WORDS - ser_cnt_q;
    assign push    = (ser_cnt_q != 3'h0) && fifo_in_ready;

    always_comb
    begin
        ser_cnt_d = ser_cnt_q;
        if (res_valid)
        begin
            ser_cnt_d = BURST_WORDS;
        end
        else if (push)
        begin
            ser_cnt_d = ser_cnt_q - 3'h1;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            ser_cnt_q <= 3'h0;
        end
        else
        begin
            ser_cnt_q <= ser_cnt_d;
        end
    end

    // Samples pause while the queue drains; a full FIFO thus holds the source off
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            smp_ready_q <= 1'b0;
        end
        else
        begin
            smp_ready_q <= (ser_cnt_d == 3'h0) && !accept;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            strobe_q <= 1'b0;
        end
        else
        begin
            strobe_q <= res_valid;
        end
    end

    ofw_fifo #(
        .W     (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLK_SYS),
        .rst       (SYS_RST),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (upper_q[ser_idx]),
        .out_valid (fifo_out_valid),
        .out_ready (pop),
        .out_data  (fifo_out_data),
        .level     (fifo_level)
    );

    assign pop     = RD && (ADDR == REG_BURST) && fifo_out_valid;
    assign reg_idx = ADDR - REG_GX_UP;

    // Read data stand one cycle after the strobe; unmapped or idle reads give zero
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            rdata_q <= '0;
        end
        else if (RD)
        begin
            if (ADDR == REG_DEC)
            begin
                rdata_q <= WORD_W'(dec_q);
            end
            else if (ADDR == REG_BART)
            begin
                rdata_q <= WORD_W'(bart_q);
            end
            else if (ADDR >= REG_GX_UP && ADDR <= REG_AZ_LOW)
            begin
                rdata_q <= reg_idx[0] ? lower_q[reg_idx[3:1]] : upper_q[reg_idx[3:1]];
            end
            else if (ADDR == REG_BURST)
            begin
                rdata_q <= fifo_out_valid ? fifo_out_data : '0;
            end
            else if (ADDR == REG_STATUS)
            begin
                rdata_q <= WORD_W'({fifo_level, ser_cnt_q != 3'h0});
            end
            else
            begin
                rdata_q <= '0;
            end
        end
        else
        begin
            rdata_q <= '0;
        end
    end

    assign gx_low16 = acc_data[0][15:0];
    assign gx_low3  = acc_data[0][2:0];
    assign ax_hi16  = acc_data[3][19:4];
    assign ax_lo4   = acc_data[3][3:0];

    a_gyro_default: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (res_valid && dec_q == 4'h0 && bart_q == 2'h0)
        |=> (upper_q[0] == $past(gx_low16) && lower_q[0] == 16'h0000))
        else $error("Default gyro result not held whole in upper");

    a_gyro_lower: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (res_valid && dec_q == 4'h7 && bart_q == 2'h0)
        |=> lower_q[0] == {$past(gx_low3), 13'h0000})
        else $error("Gyro growth bits misplaced in lower");

    a_growth_combo: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (dec_q == 4'h7 && bart_q == 2'h2) |-> gyro_w == 6'h17)
        else $error("Gyro width not 23 for decimation 7, Bartlett 2");

    a_growth_dec: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (dec_q == 4'h7 && bart_q == 2'h0) |-> gyro_w == 6'h13)
        else $error("Decimation 7 does not add three bits");

    a_growth_bart: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (dec_q == 4'h0 && bart_q == 2'h2) |-> accel_w == 6'h18)
        else $error("Bartlett 2 does not add two bits per stage");

    a_accel_default: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (res_valid && dec_q == 4'h0 && bart_q == 2'h0)
        |=> (upper_q[3] == $past(ax_hi16) && lower_q[3] == {$past(ax_lo4), 12'h000}))
        else $error("Default accel split wrong");

    a_accel_width: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (dec_q == 4'h0 && bart_q == 2'h0) |-> accel_w == 6'h14)
        else $error("Default accel width not 20");

    a_accel_growth: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (dec_q == 4'h1 && bart_q == 2'h1) |-> accel_w == 6'h17)
        else $error("Accel width not 23 for settings 1 and 1");

    a_burst_upper: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        ((res_valid && dec_q == 4'h0 && bart_q == 2'h0) ##1 push [*4])
        |-> (ser_idx == 3'h3 && upper_q[ser_idx] == $past(ax_hi16, 4)))
        else $error("Burst slot for accel x is not its upper word");

    a_lower_zero: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (res_valid && dec_q == 4'h1 && bart_q == 2'h1)
        |=> lower_q[3][8:0] == 9'h000)
        else $error("Unused lower bits not zero");

    a_ready_drop: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        accept |=> !smp_ready_q ##1 (ser_cnt_q != 3'h0 || smp_ready_q))
        else $error("Sample ready did not pause after accept");

endmodule : ofw_top

/* File: test/ofw_host.sv */
// Host model: register port master that reads the formatted results
`timescale 1ns/1ps
module ofw_host (
    input  wire logic                       clk,
    output logic [ofw_pkg::ADDR_W-1:0]      addr,
    output logic [ofw_pkg::WORD_W-1:0]      wdata,
    output logic                            wr,
    output logic                            rd,
    input  wire logic [ofw_pkg::WORD_W-1:0] rdata
);
    import ofw_pkg::*;

    initial
    begin
        addr  = '0;
        wdata = '0;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    // An idle cycle follows each strobe so no strobe is assigned twice in one step
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        @(posedge clk);
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [WORD_W-1:0] d);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask : rd_reg

endmodule : ofw_host

/* File: test/tb_ofw_top.sv */
// Self-checking bench for the output word formatting block
`timescale 1ns/1ps
module tb_ofw_top;
    import ofw_pkg::*;

    logic              clk_sys;
    logic              sys_rst;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
    logic              wr;
    logic              rd;
    logic [WORD_W-1:0] rdata;
    logic              smp_valid;
    logic              smp_ready;
    logic [15:0]       gyro [3];
    logic [19:0]       accel [3];
    logic              result_strobe;
    logic [WORD_W-1:0] exp_reg [12];
    logic [WORD_W-1:0] rv;
    int                n_mismatch = 0;
    int                n_checks = 0;
    int                tn [6] = '{7, 0, 7, 1, 15, 2};
    int                tbw [6] = '{0, 2, 2, 1, 3, 3};

    ofw_top ofw_top_inst (
        .CLK_SYS       (clk_sys),
        .SYS_RST       (sys_rst),
        .ADDR          (addr),
        .WDATA         (wdata),
        .WR            (wr),
        .RD            (rd),
        .RDATA         (rdata),
        .SMP_VALID     (smp_valid),
        .SMP_READY     (smp_ready),
        .SMP_GYRO_X    (gyro[0]),
        .SMP_GYRO_Y    (gyro[1]),
        .SMP_GYRO_Z    (gyro[2]),
        .SMP_ACCEL_X   (accel[0]),
        .SMP_ACCEL_Y   (accel[1]),
        .SMP_ACCEL_Z   (accel[2]),
        .RESULT_STROBE (result_strobe)
    );

    ofw_host ofw_host_inst (
        .clk   (clk_sys),
        .addr  (addr),
        .wdata (wdata),
        .wr    (wr),
        .rd    (rd),
        .rdata (rdata)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] want,
                         input string what);
        n_checks++;
        if (got !== want)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s got %h want %h", $time, what, got, want);
        end
    endtask : check

    task automatic timeout(input string what);
        n_mismatch++;
        $display("MISMATCH t=%0t no progress: %s", $time, what);
        tally_and_finish();
    endtask : timeout

    function automatic int clog2n(input int n);
        int g;
        g = 0;
        while ((1 << g) < n)
            g++;
        return g;
    endfunction : clog2n

    // Plain sum of a steady input, left-justified into 32 bits
    function automatic logic [31:0] just(input longint s, input int n, input int b,
                                         input int base);
        longint sum;
        int     w;
        sum = s * (n + 1) * (1 << (2 * b));
        w = base + clog2n(n + 1) + 2 * b;
        return 32'(sum << (32 - w));
    endfunction : just

    task automatic fill_exp(input int n, input int b);
        logic [31:0] lj;
        for (int k = 0; k < 6; k++)
        begin
            if (k < 3)
                lj = just($signed(gyro[k]), n, b, GYRO_BASE_W);
            else
                lj = just($signed(accel[k - 3]), n, b, ACCEL_BASE_W);
            exp_reg[2 * k]     = lj[31:16];
            exp_reg[2 * k + 1] = lj[15:0];
        end
    endtask : fill_exp

    task automatic feed(input int n);
        int k;
        int t;
        k = 0;
        t = 0;
        smp_valid <= 1'b1;
        while (k < n)
        begin
            @(negedge clk_sys);
            if (smp_ready === 1'b1)
                k++;
            @(posedge clk_sys);
            t++;
            if (k == n)
                smp_valid <= 1'b0;
            if (t > 200)
                timeout("sample intake");
        end
    endtask : feed

    task automatic wait_strobe;
        int t;
        t = 0;
        while (result_strobe !== 1'b1)
        begin
            @(negedge clk_sys);
            t++;
            if (t > 100)
                timeout("result strobe");
        end
        @(negedge clk_sys);
        check({15'h0000, result_strobe}, 16'h0000, "strobe longer than one cycle");
        @(posedge clk_sys);
    endtask : wait_strobe

    task automatic pop_words(input int cnt, input bit chk);
        logic [WORD_W-1:0] v;
        for (int i = 0; i < cnt; i++)
        begin
            ofw_host_inst.rd_reg(REG_BURST, v);
            if (chk)
                check(v, exp_reg[2 * (i % 6)], "burst word");
        end
    endtask : pop_words

    task automatic run(input int n, input int b);
        logic [WORD_W-1:0] v;
        int                warm;
        // Extremes of the sample range at the widest setting; one assignment per input
        for (int i = 0; i < 3; i++)
        begin
            if (n == 15 && b == 3 && i == 0)
                gyro[i] <= 16'h8000;
            else
                gyro[i] <= 16'($urandom);
            if (n == 15 && b == 3 && i == 2)
                accel[i] <= 20'h7FFFF;
            else
                accel[i] <= 20'($urandom);
        end
        ofw_host_inst.wr_reg(REG_DEC, 16'(n));
        ofw_host_inst.wr_reg(REG_BART, 16'(b));
        ofw_host_inst.rd_reg(REG_BART, v);
        check(v, 16'(b), "bartlett readback");
        fill_exp(n, b);
        // Enough groups to flush the filter history before comparing
        warm = (16 + n) / (n + 1);
        for (int r = 0; r <= warm; r++)
        begin
            feed(n + 1);
            wait_strobe();
            repeat (8) @(posedge clk_sys);
            pop_words(6, r == warm);
        end
        for (int a = 0; a < 12; a++)
        begin
            ofw_host_inst.rd_reg(ADDR_W'(a + 2), v);
            check(v, exp_reg[a], "result register");
        end
        $display("test dec=%0d bart=%0d done", n, b);
    endtask : run

    initial
    begin
        sys_rst   = 1'b1;
        smp_valid = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            gyro[i]  = '0;
            accel[i] = '0;
        end
        void'($urandom(56547));
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        for (int a = 0; a < 16; a++)
        begin
            ofw_host_inst.rd_reg(ADDR_W'(a), rv);
            check(rv, 16'h0000, "reset value");
        end
        $display("test reset values done");
        run(0, 0);
        // Three results without draining fill the burst buffer; two words wait to be queued
        feed(3);
        repeat (12) @(posedge clk_sys);
        ofw_host_inst.rd_reg(REG_STATUS, rv);
        check(rv, 16'h0021, "buffer level when full");
        smp_valid <= 1'b1;
        repeat (4)
        begin
            @(negedge clk_sys);
            check({15'h0000, smp_ready}, 16'h0000, "intake while full");
        end
        @(posedge clk_sys);
        smp_valid <= 1'b0;
        pop_words(18, 1'b1);
        repeat (4) @(posedge clk_sys);
        ofw_host_inst.rd_reg(REG_STATUS, rv);
        check(rv, 16'h0000, "status when drained");
        ofw_host_inst.rd_reg(REG_BURST, rv);
        check(rv, 16'h0000, "empty burst read");
        ofw_host_inst.wr_reg(REG_GX_UP, ~exp_reg[0]);
        ofw_host_inst.rd_reg(REG_GX_UP, rv);
        check(rv, exp_reg[0], "read-only write ignored");
        $display("test buffer fill and drain done");
        for (int i = 0; i < 6; i++)
            run(tn[i], tbw[i]);
        for (int i = 0; i < 3; i++)
            run(int'($urandom % 16), int'($urandom % 4));
        tally_and_finish();
    end

endmodule : tb_ofw_top
